// ===== verilog/pfc_loader.sv
// Purpose: configuration pin logic with active parallel flash master
// Assumes: option bits are static while a load runs
// Notes:   serial schemes sample data line 0 on the passive strobe
`timescale 1ns/1ns
`default_nettype none

// Operation
// - byte or word data per selected scheme
// - serial schemes float data lines above bit one while loading
// - after parallel passive, bits 2-7 follow dual-purpose setting
// - upper byte floats except active parallel user control
// - drive 24-bit flash address in active parallel
// - drive flash reset low to reset flash
// - address-valid low marks address during access
// - output enable low during read; flash drives
// - write strobe low marks driven write data
// - ready input is ignored entirely
// - error output follows detector when checking enabled
// - enabled clear input low clears all registers but the pin synchronisers
// - clear never affects test port operations
// - enabled output-enable low floats every pin
// - init-done pin released high entering user mode
// - enabled init-done pin stays status, never user
// - user start-up clock paces initialization when enabled
// - chip select low selects flash in active parallel
module pfc_loader (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // load control
  input  wire pfc_pkg::pfc_scheme_e      scheme,
  input  wire logic                      config_start,
  input  wire logic [pfc_pkg::ADDR_W-1:0] config_word_count,
  // option settings
  input  wire logic                      crc_check_enable,
  input  wire logic                      clear_option_enable,
  input  wire logic                      output_enable_option,
  input  wire logic                      init_done_enable,
  input  wire logic                      startup_clock_enable,
  input  wire logic                      dual_purpose_user_io,
  input  wire logic                      test_port_active,
  // device-wide pins
  input  wire logic                      global_clear_in_n,
  input  wire logic                      global_output_enable_in,
  input  wire logic                      user_startup_clock,
  input  wire logic                      crc_fault_detected,
  input  wire logic                      data_strobe_in,
  // flash control pins
  output logic [pfc_pkg::ADDR_W-1:0]     flash_address_bus,
  output logic                           flash_reset_out_n,
  output logic                           address_valid_out_n,
  output logic                           flash_read_enable_n,
  output logic                           flash_write_strobe_n,
  output logic                           flash_select_n,
  input  wire logic                      flash_ready_in,
  output logic                           flash_pins_oe_n,
  // data pins
  input  wire logic [pfc_pkg::DATA_W-1:0] data_in,
  output logic [pfc_pkg::DATA_W-1:0]     data_out,
  output logic [pfc_pkg::DATA_W-1:0]     data_oe_n,
  // user side of the data pins and flash writes
  input  wire logic [pfc_pkg::DATA_W-1:0] user_data_out,
  input  wire logic [pfc_pkg::DATA_W-1:0] user_data_oe_n,
  input  wire logic                      user_flash_write,
  input  wire logic [pfc_pkg::ADDR_W-1:0] user_flash_address,
  input  wire logic [pfc_pkg::DATA_W-1:0] user_flash_data,
  output logic                           user_flash_busy,
  // configuration stream
  output logic [pfc_pkg::DATA_W-1:0]     cfg_data,
  output logic                           cfg_valid,
  output logic                           cfg_is_word,
  // status
  output logic                           init_done_out,
  output logic                           init_done_oe_n,
  output logic                           crc_error,
  output logic                           user_mode,
  output logic                           device_clear
);
  import pfc_pkg::*;

  // pin synchronisers: stage one feeds stage two only
  logic [DATA_W-1:0] data_s1;
  logic [DATA_W-1:0] data_s2;
  logic [3:0]        pin_s1;
  logic [3:0]        pin_s2;
  logic              strobe_d;
  logic              uclk_d;

  always_ff @(posedge clock) begin
    if (reset) begin
      data_s1  <= DATA_RESET;
      data_s2  <= DATA_RESET;
      pin_s1   <= 4'hf;
      pin_s2   <= 4'hf;
      // match the reset level of stage two so no false edge follows reset
      strobe_d <= 1'b1;
      uclk_d   <= 1'b1;
    end else begin
      data_s1  <= data_in;
      data_s2  <= data_s1;
      pin_s1   <= {global_clear_in_n, global_output_enable_in,
                   data_strobe_in, user_startup_clock};
      pin_s2   <= pin_s1;
      strobe_d <= pin_s2[1];
      uclk_d   <= pin_s2[0];
    end
  end

  logic clear_sync_n;
  logic oe_sync;
  logic strobe_rise;
  logic uclk_rise;
  assign clear_sync_n = pin_s2[3];
  assign oe_sync      = pin_s2[2];
  assign strobe_rise  = pin_s2[1] & ~strobe_d;
  assign uclk_rise    = pin_s2[0] & ~uclk_d;

  // test port accesses hold the clear off so they are never disturbed
  assign device_clear = clear_option_enable & ~clear_sync_n & ~test_port_active;

  // the ready pin is deliberately left unread: no access waits on it
  logic unused_ready;
  assign unused_ready = flash_ready_in;

  pfc_state_e        state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [ADDR_W-1:0] words, next_words;
  logic [7:0]        shift, next_shift;
  logic [2:0]        bitcnt, next_bitcnt;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] next_cfg_data;
  logic              next_cfg_valid;
  logic              next_cfg_is_word;
  logic              next_crc_error;
  logic              init_tick;

  assign init_tick = startup_clock_enable ? uclk_rise : 1'b1;

  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_addr        = addr;
    next_words       = words;
    next_shift       = shift;
    next_bitcnt      = bitcnt;
    next_wdata       = wdata;
    next_cfg_data    = cfg_data;
    next_cfg_valid   = 1'b0;
    next_cfg_is_word = cfg_is_word;
    next_crc_error   = crc_check_enable & crc_fault_detected;
    unique case (state)
      ST_IDLE: begin
        if (config_start) begin
          next_words  = ADDR_RESET;
          next_cnt    = '0;
          next_bitcnt = '0;
          next_addr   = ADDR_RESET;
          next_state  = (scheme == active_parallel_scheme) ? ST_FLASH_RST : ST_PASSIVE;
        end
      end
      ST_FLASH_RST: begin
        next_cnt = cnt + 8'h01;
        if (cnt == FLASH_RESET_CYC - 8'h01) begin
          next_cnt   = '0;
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // address stands with valid low one cycle before the read enable
        next_cnt   = '0;
        next_state = ST_READ;
      end
      ST_READ: begin
        next_cnt = cnt + 8'h01;
        if (cnt == READ_CYC - 8'h01) begin
          next_cfg_data    = data_s2;
          next_cfg_valid   = 1'b1;
          next_cfg_is_word = 1'b1;
          next_addr        = addr + 24'h000001;
          next_words       = words + 24'h000001;
          next_state       = (words + 24'h000001 == config_word_count) ? ST_INIT : ST_ADDR;
          next_cnt         = '0;
        end
      end
      ST_PASSIVE: begin
        if (strobe_rise) begin
          if (scheme == fast_passive_parallel_scheme) begin
            next_cfg_data    = {8'h00, data_s2[7:0]};
            next_cfg_valid   = 1'b1;
            next_cfg_is_word = 1'b0;
            next_words       = words + 24'h000001;
          end else begin
            next_shift  = {shift[6:0], data_s2[0]};
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == SERIAL_LAST_BIT) begin
              next_cfg_data    = {8'h00, shift[6:0], data_s2[0]};
              next_cfg_valid   = 1'b1;
              next_cfg_is_word = 1'b0;
              next_words       = words + 24'h000001;
            end
          end
        end
        if (next_words == config_word_count) begin
          next_cnt   = '0;
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_tick) begin
          next_cnt = cnt + 8'h01;
          if (cnt == INIT_CLOCKS - 8'h01) begin
            next_state = ST_USER;
          end
        end
      end
      ST_USER: begin
        // flash writes only exist where the flash pins stay ours
        if (user_flash_write && scheme == active_parallel_scheme) begin
          next_addr  = user_flash_address;
          next_wdata = user_flash_data;
          next_state = ST_WR_ADDR;
        end
      end
      ST_WR_ADDR: begin
        next_cnt   = '0;
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        next_cnt = cnt + 8'h01;
        if (cnt == WRITE_CYC - 8'h01) begin
          next_state = ST_USER;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset || device_clear) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      addr        <= ADDR_RESET;
      words       <= ADDR_RESET;
      shift       <= 8'h00;
      bitcnt      <= 3'h0;
      wdata       <= DATA_RESET;
      cfg_data    <= DATA_RESET;
      cfg_valid   <= 1'b0;
      cfg_is_word <= 1'b0;
      crc_error   <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      addr        <= next_addr;
      words       <= next_words;
      shift       <= next_shift;
      bitcnt      <= next_bitcnt;
      wdata       <= next_wdata;
      cfg_data    <= next_cfg_data;
      cfg_valid   <= next_cfg_valid;
      cfg_is_word <= next_cfg_is_word;
      crc_error   <= next_crc_error;
    end
  end

  // pin drive
  logic force_float;
  logic ap_loading;
  logic [DATA_W-1:0] load_oe_n;
  logic [DATA_W-1:0] user_oe_n;

  assign force_float = output_enable_option & ~oe_sync;
  assign ap_loading  = (state == ST_FLASH_RST) || (state == ST_ADDR) || (state == ST_READ);
  assign user_mode   = (state == ST_USER) || (state == ST_WR_ADDR) || (state == ST_WRITE);
  assign user_flash_busy = (state == ST_WR_ADDR) || (state == ST_WRITE);

  assign flash_address_bus    = addr;
  assign flash_reset_out_n    = (state != ST_FLASH_RST);
  assign address_valid_out_n  = ~((state == ST_ADDR) || (state == ST_READ)
                                  || (state == ST_WR_ADDR) || (state == ST_WRITE));
  assign flash_read_enable_n  = (state != ST_READ);
  assign flash_write_strobe_n = (state != ST_WRITE);
  assign flash_select_n       = ~(ap_loading || user_flash_busy);
  assign flash_pins_oe_n      = force_float | ~(ap_loading || user_mode)
                                | (scheme != active_parallel_scheme);

  always_comb begin
    // during any load every data pin is an input or floats
    load_oe_n = {DATA_W{1'b1}};
    user_oe_n = user_data_oe_n;
    if (scheme == fast_passive_parallel_scheme && !dual_purpose_user_io) begin
      user_oe_n[7:SERIAL_HI_LSB] = {(8 - SERIAL_HI_LSB){1'b1}};
    end
    if (scheme == active_parallel_scheme && user_flash_busy) begin
      user_oe_n = {DATA_W{1'b0}};
    end
    // upper byte belongs to the user only after an active parallel load
    if (scheme != active_parallel_scheme) begin
      user_oe_n[DATA_W-1:UPPER_BYTE_LSB] = {(DATA_W - UPPER_BYTE_LSB){1'b1}};
    end
    if (force_float) begin
      data_oe_n = {DATA_W{1'b1}};
    end else if (user_mode) begin
      data_oe_n = user_oe_n;
    end else begin
      data_oe_n = load_oe_n;
    end
  end

  assign data_out = user_flash_busy ? wdata : user_data_out;

  // open drain: held low until user mode, then released; when the option
  // is off the pin is simply released and left to the pull-up
  assign init_done_out  = 1'b0;
  assign init_done_oe_n = force_float | ~init_done_enable | user_mode;

endmodule : pfc_loader

`default_nettype wire

// ===== common/pfc_pkg.sv
// Purpose: shared constants and types for the configuration pin logic
// Assumes: 125 MHz system clock, 8 ns period
// Notes:   times are kept in ns; cycle counts derive from them
package pfc_pkg;
  localparam int          ADDR_W           = 24;
  localparam int          DATA_W           = 16;
  localparam int          CNT_W            = 8;
  localparam int          CLOCK_PERIOD_NS  = 8;
  // least flash reset pulse width, rounded up to whole cycles
  localparam int          FLASH_RESET_NS   = 100;
  localparam logic [7:0]  FLASH_RESET_CYC  =
    8'((FLASH_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  // least read access time with output enable low, rounded up
  localparam int          READ_ACCESS_NS   = 90;
  localparam logic [7:0]  READ_CYC         =
    8'((READ_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  // least write strobe width, rounded up
  localparam int          WRITE_PULSE_NS   = 60;
  localparam logic [7:0]  WRITE_CYC        =
    8'((WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  // start-up clocks counted during initialization
  localparam logic [7:0]  INIT_CLOCKS      = 8'h08;
  localparam logic [2:0]  SERIAL_LAST_BIT  = 3'h7;
  localparam logic [23:0] ADDR_RESET       = 24'h000000;
  localparam logic [15:0] DATA_RESET       = 16'h0000;
  localparam int          SERIAL_HI_LSB    = 2;
  localparam int          UPPER_BYTE_LSB   = 8;

  typedef enum logic [1:0] {
    active_serial_scheme,
    passive_serial_scheme,
    fast_passive_parallel_scheme,
    active_parallel_scheme
  } pfc_scheme_e;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FLASH_RST,
    ST_ADDR,
    ST_READ,
    ST_PASSIVE,
    ST_INIT,
    ST_USER,
    ST_WR_ADDR,
    ST_WRITE
  } pfc_state_e;
endpackage : pfc_pkg

// ===== test/pfc_flash_model.sv
// Purpose: parallel flash partner serving configuration words
// Assumes: word content is derived from the address
// Notes:   a released bus shows the inverse of the word, not a held value
`timescale 1ns/1ns
`default_nettype none
module pfc_flash_model (
  // flash control
  input  wire logic        flash_reset_out_n,
  input  wire logic        flash_select_n,
  input  wire logic        flash_read_enable_n,
  input  wire logic [23:0] flash_address_bus,
  // toward the device
  output logic      [15:0] flash_data,
  output logic             flash_ready
);
  logic driving;
  logic [15:0] word;
  // held in reset, the flash never drives
  assign driving = !flash_select_n && !flash_read_enable_n && flash_reset_out_n;
  assign word = flash_address_bus[15:0] ^ 16'ha5c3;
  assign flash_data = driving ? word : ~word;
  assign flash_ready = driving;
endmodule : pfc_flash_model
`default_nettype wire

// ===== test/pfc_loader_assertions.sv
// Purpose: port checker for the configuration pin logic
// Assumes: one clock domain, synchronous reset
// Notes:   long pulses are split into repetitions of at most 8
`timescale 1ns/1ns
`default_nettype none
module pfc_loader_assertions
  import pfc_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // settings
  input wire pfc_scheme_e scheme,
  input wire logic        crc_check_enable,
  input wire logic        crc_fault_detected,
  input wire logic        output_enable_option,
  input wire logic        global_output_enable_in,
  input wire logic        init_done_enable,
  // flash pins
  input wire logic        flash_reset_out_n,
  input wire logic        address_valid_out_n,
  input wire logic        flash_read_enable_n,
  input wire logic        flash_write_strobe_n,
  input wire logic        flash_select_n,
  input wire logic        flash_pins_oe_n,
  // data pins and status
  input wire logic [15:0] data_oe_n,
  input wire logic        crc_error,
  input wire logic        user_mode,
  input wire logic        device_clear,
  input wire logic        init_done_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rst; !flash_reset_out_n [*8] ##1 !flash_reset_out_n [*5] ##1 flash_reset_out_n; endsequence
  sequence s_rd; !flash_read_enable_n [*8] ##1 !flash_read_enable_n [*4] ##1 flash_read_enable_n; endsequence
  sequence s_wr; !flash_write_strobe_n [*8] ##1 flash_write_strobe_n; endsequence
  property p_rst_pulse; $fell(flash_reset_out_n) |-> s_rst; endproperty
  property p_rd_pulse; $fell(flash_read_enable_n) |-> s_rd; endproperty
  property p_wr_pulse; $fell(flash_write_strobe_n) |-> s_wr; endproperty
  property p_avd_first;
    $fell(flash_read_enable_n) |-> $past(address_valid_out_n) == 1'b0 && !flash_select_n;
  endproperty
  property p_wr_avd;
    $fell(flash_write_strobe_n) |-> $past(address_valid_out_n) == 1'b0 && data_oe_n == 16'h0000;
  endproperty
  property p_crc;
    crc_check_enable && crc_fault_detected && !device_clear |=> crc_error;
  endproperty
  property p_upper; scheme != active_parallel_scheme |-> data_oe_n[15:8] == 8'hff; endproperty
  property p_serial;
    scheme inside {active_serial_scheme, passive_serial_scheme} && !user_mode
      |-> data_oe_n[15:2] == 14'h3fff;
  endproperty
  property p_float;
    (output_enable_option && !global_output_enable_in) [*4] |-> &data_oe_n && flash_pins_oe_n;
  endproperty
  property p_done; $rose(user_mode) && init_done_enable |-> init_done_oe_n; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("flash reset pulse length");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read enable pulse length");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe pulse length");
  a_avd_first: assert property (p_avd_first) else $error("read before address valid");
  a_wr_avd: assert property (p_wr_avd) else $error("write without address or data");
  a_crc: assert property (p_crc) else $error("error flag not raised");
  a_upper: assert property (p_upper) else $error("upper byte driven");
  a_serial: assert property (p_serial) else $error("data lines driven in serial load");
  a_float: assert property (p_float) else $error("pins driven under float");
  a_done: assert property (p_done) else $error("init done not released");
endmodule : pfc_loader_assertions
`default_nettype wire

// ===== test/pfc_loader_tb_top.sv
// Purpose: self-checking bench for the configuration pin logic
// Assumes: flash partner model on the active parallel pins
// Notes:   results are checked at the falling edge, where they are settled; the init-done checks after wait_mode run at a rising edge
`timescale 1ns/1ns
`default_nettype none
module pfc_loader_tb_top;
  import pfc_pkg::*;
  logic clock, reset, config_start, crc_check_enable, clear_option_enable, output_enable_option;
  logic init_done_enable, startup_clock_enable, dual_purpose_user_io, test_port_active;
  logic global_clear_in_n, global_output_enable_in, user_startup_clock, crc_fault_detected;
  logic data_strobe_in, flash_reset_out_n, address_valid_out_n, flash_read_enable_n;
  logic flash_write_strobe_n, flash_select_n, flash_ready_in, flash_pins_oe_n, user_flash_write;
  logic user_flash_busy, cfg_valid, cfg_is_word, init_done_out, init_done_oe_n, crc_error;
  logic user_mode, device_clear;
  logic [23:0] config_word_count, flash_address_bus, user_flash_address;
  logic [15:0] data_in, data_out, data_oe_n, user_data_out, user_data_oe_n, user_flash_data;
  logic [15:0] cfg_data, flash_data, tb_data;
  logic [31:0] seed = 32'hb20f2a41, r, err_total = 0, comparisons = 0, cycles = 0;
  logic [2:0] phase = 3'h0;
  logic [16:0] exp_q[$];
  pfc_scheme_e scheme;
  assign data_in = (scheme == active_parallel_scheme) ? flash_data : tb_data;
  assign user_startup_clock = phase[2];
  pfc_loader u_dut (.clock, .reset, .scheme, .config_start, .config_word_count,
    .crc_check_enable, .clear_option_enable, .output_enable_option, .init_done_enable,
    .startup_clock_enable, .dual_purpose_user_io, .test_port_active, .global_clear_in_n,
    .global_output_enable_in, .user_startup_clock, .crc_fault_detected, .data_strobe_in,
    .flash_address_bus, .flash_reset_out_n, .address_valid_out_n, .flash_read_enable_n,
    .flash_write_strobe_n, .flash_select_n, .flash_ready_in, .flash_pins_oe_n, .data_in,
    .data_out, .data_oe_n, .user_data_out, .user_data_oe_n, .user_flash_write,
    .user_flash_address, .user_flash_data, .user_flash_busy, .cfg_data, .cfg_valid,
    .cfg_is_word, .init_done_out, .init_done_oe_n, .crc_error, .user_mode, .device_clear);
  pfc_flash_model u_flash (.flash_reset_out_n, .flash_select_n, .flash_read_enable_n,
    .flash_address_bus, .flash_data, .flash_ready(flash_ready_in));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task look(input int n);
    tick(n);
    @(negedge clock);
  endtask : look
  // strobe held 4 clocks high and low, above the 2 the synchroniser needs
  task strobe();
    data_strobe_in <= 1'b1;
    tick(4);
    data_strobe_in <= 1'b0;
    tick(4);
  endtask : strobe
  task restart(input pfc_scheme_e s, input logic [23:0] n);
    reset <= 1'b1;
    scheme <= s;
    config_word_count <= n;
    tick(3);
    reset <= 1'b0;
    config_start <= 1'b1;
    tick(1);
    config_start <= 1'b0;
  endtask : restart
  task wait_mode();
    for (int i = 0; i < 300 && user_mode !== 1'b1; i++) @(negedge clock);
    chk(user_mode, 1);
    tick(1);
  endtask : wait_mode
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    phase <= phase + 3'h1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  always @(negedge clock) begin
    if (cfg_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else chk({cfg_is_word, cfg_is_word ? cfg_data : {8'h00, cfg_data[7:0]}}, exp_q.pop_front());
    end
  end
  initial begin
    {config_start, crc_check_enable, clear_option_enable, output_enable_option} <= '0;
    {startup_clock_enable, dual_purpose_user_io, test_port_active, crc_fault_detected} <= '0;
    {data_strobe_in, user_flash_write, user_flash_address, user_flash_data} <= '0;
    {user_data_out, user_data_oe_n, tb_data, config_word_count} <= '0;
    scheme <= active_serial_scheme;
    {init_done_enable, global_clear_in_n, global_output_enable_in, reset} <= '1;
    tick(2);
    for (int i = 0; i < 3; i++) exp_q.push_back({1'b1, 16'(i) ^ 16'ha5c3});
    restart(active_parallel_scheme, 24'h000003);
    wait_mode();
    chk(init_done_oe_n, 1);
    chk(init_done_out, 0);
    r = rnd();
    user_data_oe_n <= r[15:0];
    user_data_out <= r[31:16];
    crc_check_enable <= 1'b1;
    crc_fault_detected <= 1'b1;
    look(2);
    chk(data_oe_n, user_data_oe_n);
    chk(crc_error, 1);
    tick(1);
    r = rnd();
    user_flash_address <= r[23:0];
    user_flash_data <= r[31:16];
    user_flash_write <= 1'b1;
    tick(1);
    user_flash_write <= 1'b0;
    for (int i = 0; i < 20 && flash_write_strobe_n !== 1'b0; i++) @(negedge clock);
    chk(data_out, user_flash_data);
    chk(flash_address_bus, user_flash_address);
    chk(user_flash_busy, 1);
    tick(1);
    $display("test active parallel done");
    startup_clock_enable <= 1'b1;
    restart(fast_passive_parallel_scheme, 24'h000002);
    repeat (2) begin
      r = rnd();
      tb_data <= r[15:0];
      exp_q.push_back({9'h000, r[7:0]});
      strobe();
    end
    wait_mode();
    user_data_oe_n <= 16'h0000;
    look(2);
    chk(data_oe_n, 16'hfffc);
    tick(1);
    dual_purpose_user_io <= 1'b1;
    look(2);
    chk(data_oe_n, 16'hff00);
    tick(1);
    output_enable_option <= 1'b1;
    global_output_enable_in <= 1'b0;
    look(5);
    chk(data_oe_n, 16'hffff);
    chk(flash_pins_oe_n, 1);
    tick(1);
    clear_option_enable <= 1'b1;
    global_clear_in_n <= 1'b0;
    test_port_active <= 1'b1;
    look(5);
    chk(device_clear, 0);
    chk(user_mode, 1);
    tick(1);
    test_port_active <= 1'b0;
    look(5);
    chk(device_clear, 1);
    chk(user_mode, 0);
    tick(1);
    {global_clear_in_n, global_output_enable_in} <= 2'h3;
    $display("test fast passive done");
    restart(passive_serial_scheme, 24'h000001);
    r = rnd();
    exp_q.push_back({9'h000, r[7:0]});
    for (int k = 7; k >= 0; k--) begin
      tb_data <= {15'h0000, r[k]};
      strobe();
    end
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clock);
    chk(exp_q.size(), 0);
    $display("test serial done");
    report_and_stop();
  end
endmodule : pfc_loader_tb_top
bind pfc_loader pfc_loader_assertions u_chk (.clock, .reset, .scheme, .crc_check_enable,
  .crc_fault_detected, .output_enable_option, .global_output_enable_in, .init_done_enable,
  .flash_reset_out_n, .address_valid_out_n, .flash_read_enable_n, .flash_write_strobe_n,
  .flash_select_n, .flash_pins_oe_n, .data_oe_n, .crc_error, .user_mode, .init_done_oe_n,
  .device_clear);
`default_nettype wire
